//--- src/eres_pkg.sv
// shared constants and coefficient generation for the enhanced resolution filter bank
package eres_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int sample_w = 8;
	localparam int out_w = 16;
	localparam int addr_w = 16;
	localparam int sel_w = 3;
	localparam int coef_w = 16;
	localparam int coef_addr_w = 8;
	localparam int acc_w = 24;

	// ----------------------------------------
	// fixed point layout
	// ----------------------------------------
	localparam int coef_frac = 15;
	localparam int out_frac = 8;
	localparam int out_lsb = coef_frac - out_frac;
	localparam int coef_unity = 32768;

	// ----------------------------------------
	// filter bank: one entry per half-bit step, 0.5 .. 3.0 bits
	// ----------------------------------------
	localparam int setting_count = 6;
	localparam int tap_count [0:5] = '{2, 5, 10, 24, 51, 117};
	localparam int total_taps = 209;

	function automatic int tap_base(input int s);
		int b;
		b = 0;
		for (int i = 0; i < setting_count; i++) begin
			if (i < s) begin
				b += tap_count[i];
			end
		end
		return b;
	endfunction

	// triangular weight, symmetric about the centre of the response
	function automatic int tri_weight(input int len, input int k);
		return (k + 1 < len - k) ? k + 1 : len - k;
	endfunction

	// quantised weight; even lengths use even values so the centre pair can share the remainder
	function automatic int raw_coef(input int len, input int k, input int wsum);
		if (len % 2 == 0) begin
			return 2 * ((tri_weight(len, k) * (coef_unity / 2)) / wsum);
		end
		return (tri_weight(len, k) * coef_unity) / wsum;
	endfunction

	// coefficient k of setting s; remainder put on the centre tap(s) so the sum is exactly unity
	function automatic int coef_value(input int s, input int k);
		int len;
		int wsum;
		int qsum;
		int c;
		len = tap_count[s];
		wsum = 0;
		qsum = 0;
		for (int j = 0; j < len; j++) begin
			wsum += tri_weight(len, j);
		end
		for (int j = 0; j < len; j++) begin
			qsum += raw_coef(len, j, wsum);
		end
		c = raw_coef(len, k, wsum);
		if (len % 2 == 1 && k == len / 2) begin
			c += coef_unity - qsum;
		end else if (len % 2 == 0 && (k == len / 2 || k == len / 2 - 1)) begin
			c += (coef_unity - qsum) / 2;
		end
		return c;
	endfunction

	// coefficient at a flat table index spanning all six settings
	function automatic logic [15:0] flat_coef(input int i);
		int s;
		s = 0;
		for (int j = 1; j < setting_count; j++) begin
			if (i >= tap_base(j)) begin
				s = j;
			end
		end
		return 16'(coef_value(s, i - tap_base(s)));
	endfunction

endpackage

//--- src/coef_rom.sv
// coefficient table for all six filters, registered read
`timescale 1ns/10ps
module coef_rom (
	input wire logic clk,
	input wire logic [7:0] addr,
	output logic [15:0] coef
);

	logic [15:0] table_word [0:eres_pkg::total_taps-1];

	// ----------------------------------------
	// constant table, built at elaboration
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < eres_pkg::total_taps; i++) begin : g_word
			assign table_word[i] = eres_pkg::flat_coef(i);
		end
	endgenerate

	// addresses past the table read as zero
	always_ff @(posedge clk) begin
		if (addr < 8'(eres_pkg::total_taps)) begin
			coef <= table_word[addr];
		end else begin
			coef <= 16'h0000;
		end
	end

endmodule

//--- src/enhanced_resolution_fir_filter.sv
// zero-phase fir filter bank that raises the resolution of a stored sample record
//
// What this block does
// - six settings, 0.5 to 3 bits in half-bit steps; one filter per record
// - tap counts 2,5,10,24,51,117; cutoffs 0.5 down to 0.016 of nyquist
// - each half-bit step roughly halves the passband of the filter
// - added resolution is fixed per setting, independent of signal content
// - all filters symmetric fir; zero phase for odd tap counts, half a sample of lag for even ones, relative timing kept
// - group delay removed to whole samples: output index n + taps/2, the centre input index, the upper one of the centre pair for even tap counts
// - coefficients sum exactly to unity, so no overflow from clean input
// - overflowed input is filtered anyway, no error raised
// - output record shorter than source by exactly the tap count
// - record too short for any output is rejected, nothing written
`timescale 1ns/10ps
module enhanced_resolution_fir_filter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [2:0] setting_sel,
	input wire logic [15:0] src_len,
	output logic rd_en,
	output logic [15:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic wr_en,
	output logic [15:0] wr_addr,
	output logic [15:0] wr_data,
	output logic [15:0] out_len,
	output logic busy,
	output logic done,
	output logic rejected
);

	typedef enum {st_idle, st_tap, st_flush, st_store} state_t;

	state_t state;
	logic [2:0] setting;
	logic [15:0] taps;
	logic [15:0] lead;
	logic [15:0] n;
	logic [15:0] k;
	logic [15:0] last_n;
	logic [7:0] coef_addr;
	logic [15:0] coef;
	logic prod_valid;
	logic [23:0] acc;
	logic [23:0] prod;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [15:0] taps_of(input logic [2:0] s);
		logic [15:0] t;
		t = 16'h0000;
		for (int i = 0; i < eres_pkg::setting_count; i++) begin
			if (int'(s) == i) begin
				t = 16'(eres_pkg::tap_count[i]);
			end
		end
		return t;
	endfunction

	function automatic logic [7:0] base_of(input logic [2:0] s);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < eres_pkg::setting_count; i++) begin
			if (int'(s) == i) begin
				b = 8'(eres_pkg::tap_base(i));
			end
		end
		return b;
	endfunction

	function automatic logic accept(input logic [2:0] s, input logic [15:0] len);
		// an unused setting code decodes to zero taps and is refused here
		return (taps_of(s) != 16'h0000) && (len > taps_of(s));
	endfunction

	// ----------------------------------------
	// coefficient table
	// ----------------------------------------
	coef_rom i_coef_rom (
		.clk(clk),
		.addr(coef_addr),
		.coef(coef)
	);

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= st_idle;
		end else begin
			unique case (state)
				st_idle: begin
					if (start && accept(setting_sel, src_len)) begin
						state <= st_tap;
					end
				end
				st_tap: begin
					if (k == taps - 16'h0001) begin
						state <= st_flush;
					end
				end
				st_flush: begin
					// wait for the last product to land in the accumulator
					if (!rd_en && !prod_valid) begin
						state <= st_store;
					end
				end
				st_store: begin
					if (n == last_n) begin
						state <= st_idle;
					end else begin
						state <= st_tap;
					end
				end
			endcase
		end
	end

	// setting latched once so a record never mixes filters
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			setting <= 3'h0;
			taps <= 16'h0000;
			lead <= 16'h0000;
			last_n <= 16'h0000;
			out_len <= 16'h0000;
		end else if (state == st_idle && start && accept(setting_sel, src_len)) begin
			setting <= setting_sel;
			taps <= taps_of(setting_sel);
			lead <= taps_of(setting_sel) >> 1;
			last_n <= src_len - taps_of(setting_sel) - 16'h0001;
			out_len <= src_len - taps_of(setting_sel);
		end
	end

	// output index n and tap index k
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			n <= 16'h0000;
			k <= 16'h0000;
		end else if (state == st_idle) begin
			n <= 16'h0000;
			k <= 16'h0000;
		end else if (state == st_tap) begin
			k <= k + 16'h0001;
		end else if (state == st_store) begin
			n <= n + 16'h0001;
			k <= 16'h0000;
		end
	end

	// ----------------------------------------
	// sample and coefficient fetch
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_en <= 1'b0;
			rd_addr <= 16'h0000;
			coef_addr <= 8'h00;
		end else begin
			rd_en <= (state == st_tap);
			if (state == st_tap) begin
				// the window starts at n, so no output needs samples outside the record
				rd_addr <= n + k;
				coef_addr <= base_of(setting) + 8'(k);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prod_valid <= 1'b0;
		end else begin
			prod_valid <= rd_en;
		end
	end

	// ----------------------------------------
	// multiply-accumulate
	// ----------------------------------------
	// samples are unsigned quantiser codes; overflow codes pass through unchecked
	assign prod = 24'(coef * rd_data);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc <= 24'h000000;
		end else if (state == st_store || state == st_idle) begin
			acc <= 24'h000000;
		end else if (prod_valid) begin
			// unity-sum nonnegative taps keep the sum at or below 255 * 2^15, no wrap
			acc <= acc + prod;
		end
	end

	// ----------------------------------------
	// result write and status
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_en <= 1'b0;
			wr_addr <= 16'h0000;
			wr_data <= 16'h0000;
		end else begin
			wr_en <= (state == st_store);
			if (state == st_store) begin
				wr_addr <= n + lead;
				wr_data <= acc[eres_pkg::out_lsb +: eres_pkg::out_w];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			rejected <= 1'b0;
		end else begin
			if (state == st_idle && start && accept(setting_sel, src_len)) begin
				busy <= 1'b1;
			end else if (state == st_store && n == last_n) begin
				busy <= 1'b0;
			end
			done <= (state == st_store && n == last_n);
			rejected <= (state == st_idle && start && !accept(setting_sel, src_len));
		end
	end

endmodule

//--- testbench/eres_checker.sv
// port assertions for the filter bank
`timescale 1ns/10ps
module eres_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [2:0] setting_sel,
	input wire logic [15:0] src_len,
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	input wire logic wr_en,
	input wire logic [15:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] out_len,
	input wire logic busy,
	input wire logic done,
	input wire logic rejected
);
	logic [15:0] tl, tl_q;
	logic ok, acc;
	// codes 6 and 7 get a zero length; the setting_sel < 6 test keeps them from counting as acceptable
	assign tl = (setting_sel < 3'h6) ? 16'(eres_pkg::tap_count[setting_sel]) : 16'h0;
	assign ok = setting_sel < 3'h6 && src_len > tl;
	assign acc = start && !busy && ok;
	always_ff @(posedge clk) begin
		if (acc) begin
			tl_q <= tl;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_accept;
		acc |=> busy && !rejected;
	endproperty
	a_accept: assert property (p_accept) else $error("accept lost");
	property p_refuse;
		start && !busy && !ok |=> rejected && !busy;
	endproperty
	a_refuse: assert property (p_refuse) else $error("refusal lost");
	property p_quiet;
		rejected |-> !rd_en && !wr_en;
	endproperty
	a_quiet: assert property (p_quiet) else $error("traffic on refusal");
	property p_len;
		acc |=> out_len == $past(src_len) - $past(tl);
	endproperty
	a_len: assert property (p_len) else $error("out_len wrong");
	property p_first;
		acc |-> ##2 rd_en && rd_addr == 16'h0;
	endproperty
	a_first: assert property (p_first) else $error("first fetch wrong");
	property p_done;
		done |-> wr_en && !busy;
	endproperty
	a_done: assert property (p_done) else $error("done without write");
	property p_wr;
		wr_en |-> wr_addr >= tl_q / 2 && wr_addr < tl_q / 2 + out_len;
	endproperty
	a_wr: assert property (p_wr) else $error("write index out of range");
	property p_range;
		wr_en |-> wr_data <= 16'hff00;
	endproperty
	a_range: assert property (p_range) else $error("output overflow");
	c_acc: cover property (acc);
	c_rej: cover property (rejected);
	c_done: cover property (done);
endmodule
bind enhanced_resolution_fir_filter eres_checker i_eres_checker (.clk(clk), .rst_n(rst_n), .start(start),
	.setting_sel(setting_sel), .src_len(src_len), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
	.wr_addr(wr_addr), .wr_data(wr_data), .out_len(out_len), .busy(busy), .done(done), .rejected(rejected));

//--- testbench/rec_mem.sv
// sample record memory on the far side of the read port
`timescale 1ns/10ps
module rec_mem (
	input wire logic clk,
	input wire logic rd_en,
	input wire logic [15:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:255];
	initial rd_data = 8'h00;
	// junk outside a fetch so stale data cannot pass for a read
	always @(posedge clk) begin
		rd_data <= rd_en ? mem[rd_addr[7:0]] : ~rd_data;
	end
endmodule

//--- testbench/enhanced_resolution_fir_filter_test.sv
// self-checking bench for the filter bank
`timescale 1ns/10ps
module enhanced_resolution_fir_filter_test;
	logic clk, rst_n, start, rd_en, wr_en, busy, done, rejected;
	logic [2:0] setting_sel;
	logic [7:0] rd_data;
	logic [15:0] src_len, rd_addr, wr_addr, wr_data, out_len;
	int error_cnt = 0;
	int checks = 0;
	int cycles = 0;
	int seed, len, n;
	enhanced_resolution_fir_filter i_enhanced_resolution_fir_filter (.clk(clk), .rst_n(rst_n), .start(start),
		.setting_sel(setting_sel), .src_len(src_len), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .out_len(out_len), .busy(busy), .done(done),
		.rejected(rejected));
	rec_mem i_rec_mem (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
	// a ramp through a symmetric unity filter lands exactly on the centre value
	function automatic logic [15:0] expect_val(input int off, input int sl, input int a, input int l);
		return 16'((off + sl * a) * 256 - ((l % 2 == 0) ? sl * 128 : 0));
	endfunction
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic run(input int s, input int cnt, input int off, input int sl);
		int l, w, t;
		l = (s < 6) ? eres_pkg::tap_count[s] : 0;
		for (int i = 0; i < cnt; i++) begin
			i_rec_mem.mem[i] = 8'(off + sl * i);
		end
		@(posedge clk);
		start <= 1'b1;
		setting_sel <= 3'(s);
		src_len <= 16'(cnt);
		@(posedge clk);
		start <= 1'b0;
		// answer flags rise on the taking edge itself; rejected stands for that cycle only, busy stays up
		#1;
		if (s > 5 || cnt <= l) begin
			cmp("rejected", 16'h1, 16'(rejected));
			cmp("busy", 16'h0, 16'(busy));
			return;
		end
		cmp("busy", 16'h1, 16'(busy));
		cmp("rejected", 16'h0, 16'(rejected));
		w = 0;
		t = 0;
		while (done !== 1'b1 && t < 4000) begin
			@(posedge clk);
			#1;
			t++;
			if (wr_en === 1'b1) begin
				cmp("wr_addr", 16'(l / 2 + w), wr_addr);
				cmp("wr_data", expect_val(off, sl, l / 2 + w, l), wr_data);
				w++;
			end
		end
		// a run that hits the cycle limit shows up here as a missing done
		cmp("done", 16'h1, 16'(done));
		cmp("busy", 16'h0, 16'(busy));
		cmp("count", 16'(cnt - l), 16'(w));
		cmp("out_len", 16'(cnt - l), out_len);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ceiling well above the longest expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		seed = 32'hcd15720a;
		rst_n = 1'b0;
		start = 1'b0;
		setting_sel = 3'h0;
		src_len = 16'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// codes 6 and 7 take the refusal path too, on all three runs
		for (int s = 0; s < 8; s++) begin
			len = (s < 6) ? eres_pkg::tap_count[s] : 8;
			n = len + 1 + ($unsigned($random(seed)) % 16);
			run(s, len, 0, 1);
			run(s, n, $unsigned($random(seed)) % (256 - n), 1);
			run(s, len + 1, 255, 0);
		end
		give_verdict();
	end
endmodule
